// ---- shared/pgood_cfg_pkg.sv ----
// Constants for the power-good supervision configuration bank.
// Assumes an 8-bit register port driven by the serial interface logic on the same clock.
`default_nettype none
package pgood_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SOURCE_CONTROL = 8'h13;
  localparam logic [7:0] ADDR_MONITOR_ONE_LEVEL = 8'h14;
  localparam logic [7:0] ADDR_MONITOR_TWO_SUPPLY_LEVEL = 8'h15;

  // ----------------------------------------------------------------
  // Values after reset and reserved masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_SOURCE_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MONITOR_ONE_LEVEL = 8'h00;
  localparam logic [7:0] RESET_MONITOR_TWO_SUPPLY_LEVEL = 8'h00;
  localparam logic [7:0] RESERVED_SOURCE_CONTROL = 8'h80;
  localparam logic [7:0] RESERVED_MONITOR_ONE_LEVEL = 8'he0;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int METHOD_SELECT_BIT = 6;
  localparam int ANALOG_SUPPLY_ENABLE_BIT = 5;
  localparam int MONITOR_TWO_ENABLE_BIT = 4;
  localparam int MONITOR_ONE_ENABLE_BIT = 3;
  localparam int STEP_UP_ENABLE_BIT = 2;
  localparam int STEP_DOWN_B_ENABLE_BIT = 1;
  localparam int STEP_DOWN_A_ENABLE_BIT = 0;
  localparam int SOURCE_COUNT = 6;
  localparam int MONITOR_TOL_LSB = 3;
  localparam int MONITOR_LEVEL_LSB = 0;
  localparam int SUPPLY_TOL_LSB = 6;
  localparam int SUPPLY_LEVEL_BIT = 5;

  // ----------------------------------------------------------------
  // Decoded levels (mV) and tolerances (percent)
  // ----------------------------------------------------------------
  localparam logic [10:0] MON_LEVEL_0 = 11'h28a;
  localparam logic [10:0] MON_LEVEL_1 = 11'h320;
  localparam logic [10:0] MON_LEVEL_2 = 11'h3e8;
  localparam logic [10:0] MON_LEVEL_3 = 11'h44c;
  localparam logic [10:0] MON_LEVEL_4 = 11'h4b0;
  localparam logic [10:0] MON_LEVEL_5 = 11'h514;
  localparam logic [10:0] MON_LEVEL_TOP = 11'h708;
  localparam logic [3:0] MON_TOL_0 = 4'h2;
  localparam logic [3:0] MON_TOL_1 = 4'h3;
  localparam logic [3:0] MON_TOL_2 = 4'h4;
  localparam logic [3:0] MON_TOL_3 = 4'h6;
  localparam logic [12:0] SUPPLY_LEVEL_LOW = 13'h0ce4;
  localparam logic [12:0] SUPPLY_LEVEL_HIGH = 13'h1388;
  localparam logic [3:0] SUPPLY_TOL_0 = 4'h4;
  localparam logic [3:0] SUPPLY_TOL_1 = 4'h5;
  localparam logic [3:0] SUPPLY_TOL_WIDE = 4'ha;

endpackage : pgood_cfg_pkg
`default_nettype wire

// ---- rtl/monitor_level_decode.sv ----
// Decoder for one external monitor input: level code and tolerance code.
// Assumes codes come from registers on the same clock; outputs lag them by one cycle.
`timescale 1ns/1ps
`default_nettype none
module monitor_level_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Codes
  input wire logic [2:0] level_code,
  input wire logic [1:0] tol_code,
  // Decoded settings
  output logic [10:0] level_mv_q,
  output logic [3:0] tol_pct_q,
  output logic divider_en_q
);

  function automatic logic [10:0] level_of(input logic [2:0] code);
    unique case (code)
      3'h0: level_of = pgood_cfg_pkg::MON_LEVEL_0;
      3'h1: level_of = pgood_cfg_pkg::MON_LEVEL_1;
      3'h2: level_of = pgood_cfg_pkg::MON_LEVEL_2;
      3'h3: level_of = pgood_cfg_pkg::MON_LEVEL_3;
      3'h4: level_of = pgood_cfg_pkg::MON_LEVEL_4;
      3'h5: level_of = pgood_cfg_pkg::MON_LEVEL_5;
      3'h6, 3'h7: level_of = pgood_cfg_pkg::MON_LEVEL_TOP;
    endcase
  endfunction : level_of

  function automatic logic [3:0] tol_of(input logic [1:0] code);
    unique case (code)
      2'h0: tol_of = pgood_cfg_pkg::MON_TOL_0;
      2'h1: tol_of = pgood_cfg_pkg::MON_TOL_1;
      2'h2: tol_of = pgood_cfg_pkg::MON_TOL_2;
      2'h3: tol_of = pgood_cfg_pkg::MON_TOL_3;
    endcase
  endfunction : tol_of

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level_mv_q <= pgood_cfg_pkg::MON_LEVEL_0;
      tol_pct_q <= pgood_cfg_pkg::MON_TOL_0;
      divider_en_q <= 1'b0;
    end
    else
    begin
      level_mv_q <= level_of(level_code);
      tol_pct_q <= tol_of(tol_code);
      // Code zero keeps the pin high impedance for an external divider
      divider_en_q <= (level_code != 3'h0);
    end
  end

endmodule : monitor_level_decode
`default_nettype wire

// ---- rtl/power_good_monitor_config.sv ----
// Configuration bank for power-good supervision: source enables, method, levels.
// Assumes the serial interface logic drives the register port on clk and that
// the default store presents its bytes, stable, from reset release onward.
`timescale 1ns/1ps
`default_nettype none
module power_good_monitor_config (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port from serial interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Default store
  input wire logic [7:0] default_source_control,
  input wire logic [7:0] default_monitor_one_level,
  input wire logic [7:0] default_monitor_two_supply_level,
  // Device state
  input wire logic device_operating,
  // Comparator enables per source, bit order as in source control
  output logic [5:0] uv_check_en_q,
  output logic [5:0] ov_check_en_q,
  output logic monitor_method_select_q,
  // Decoded monitor settings
  output logic [10:0] monitor_one_level_mv_q,
  output logic [3:0] monitor_one_tolerance_pct_q,
  output logic monitor_one_divider_en_q,
  output logic [10:0] monitor_two_level_mv_q,
  output logic [3:0] monitor_two_tolerance_pct_q,
  output logic monitor_two_divider_en_q,
  output logic [12:0] analog_supply_level_mv_q,
  output logic [3:0] analog_supply_tolerance_pct_q,
  // Event towards interrupt logic
  output logic config_change_pulse_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] source_control_q;
  logic [7:0] monitor_one_level_q;
  logic [7:0] monitor_two_supply_level_q;
  logic load_pending_q;
  logic wr_ctrl;
  logic wr_lvl1;
  logic wr_lvl2;

  // Port writes are dropped during the single load cycle so the defaults win
  assign wr_ctrl = reg_wr && !load_pending_q && reg_addr == pgood_cfg_pkg::ADDR_SOURCE_CONTROL;
  assign wr_lvl1 = reg_wr && !load_pending_q
                   && reg_addr == pgood_cfg_pkg::ADDR_MONITOR_ONE_LEVEL;
  assign wr_lvl2 = reg_wr && !load_pending_q
                   && reg_addr == pgood_cfg_pkg::ADDR_MONITOR_TWO_SUPPLY_LEVEL;

  // Async reset takes constants only; defaults are copied on the first edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      load_pending_q <= 1'b1;
    else
      load_pending_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      source_control_q <= pgood_cfg_pkg::RESET_SOURCE_CONTROL;
    else if (load_pending_q)
      source_control_q <= default_source_control
                          & ~pgood_cfg_pkg::RESERVED_SOURCE_CONTROL;
    else if (wr_ctrl)
      source_control_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      monitor_one_level_q <= pgood_cfg_pkg::RESET_MONITOR_ONE_LEVEL;
    else if (load_pending_q)
      monitor_one_level_q <= default_monitor_one_level
                             & ~pgood_cfg_pkg::RESERVED_MONITOR_ONE_LEVEL;
    else if (wr_lvl1)
      monitor_one_level_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      monitor_two_supply_level_q <= pgood_cfg_pkg::RESET_MONITOR_TWO_SUPPLY_LEVEL;
    else if (load_pending_q)
      monitor_two_supply_level_q <= default_monitor_two_supply_level;
    else if (wr_lvl2)
      monitor_two_supply_level_q <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata_q <= pgood_cfg_pkg::UNMAPPED_READ_VALUE;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          pgood_cfg_pkg::ADDR_SOURCE_CONTROL: reg_rdata_q <= source_control_q;
          pgood_cfg_pkg::ADDR_MONITOR_ONE_LEVEL: reg_rdata_q <= monitor_one_level_q;
          pgood_cfg_pkg::ADDR_MONITOR_TWO_SUPPLY_LEVEL:
            reg_rdata_q <= monitor_two_supply_level_q;
          default: reg_rdata_q <= pgood_cfg_pkg::UNMAPPED_READ_VALUE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervision enables
  // ----------------------------------------------------------------
  logic [5:0] source_en;
  logic method_both;

  assign source_en = source_control_q[pgood_cfg_pkg::SOURCE_COUNT-1:0];
  assign method_both = source_control_q[pgood_cfg_pkg::METHOD_SELECT_BIT];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uv_check_en_q <= 6'h00;
      ov_check_en_q <= 6'h00;
      monitor_method_select_q <= 1'b0;
    end
    else
    begin
      uv_check_en_q <= source_en;
      // Overvoltage only in window mode
      ov_check_en_q <= method_both ? source_en : 6'h00;
      monitor_method_select_q <= method_both;
    end
  end

  // A live change of what is supervised can trip comparators; flag it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      config_change_pulse_q <= 1'b0;
    else
      config_change_pulse_q <= wr_ctrl && device_operating
                               && (reg_wdata[6:0] != source_control_q[6:0]);
  end

  // ----------------------------------------------------------------
  // Level and tolerance decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] supply_tol(input logic [1:0] code);
    unique case (code)
      2'h0: supply_tol = pgood_cfg_pkg::SUPPLY_TOL_0;
      2'h1: supply_tol = pgood_cfg_pkg::SUPPLY_TOL_1;
      2'h2, 2'h3: supply_tol = pgood_cfg_pkg::SUPPLY_TOL_WIDE;
    endcase
  endfunction : supply_tol

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      analog_supply_level_mv_q <= pgood_cfg_pkg::SUPPLY_LEVEL_LOW;
      analog_supply_tolerance_pct_q <= pgood_cfg_pkg::SUPPLY_TOL_0;
    end
    else
    begin
      analog_supply_level_mv_q <=
        monitor_two_supply_level_q[pgood_cfg_pkg::SUPPLY_LEVEL_BIT]
        ? pgood_cfg_pkg::SUPPLY_LEVEL_HIGH : pgood_cfg_pkg::SUPPLY_LEVEL_LOW;
      analog_supply_tolerance_pct_q <=
        supply_tol(monitor_two_supply_level_q[pgood_cfg_pkg::SUPPLY_TOL_LSB +: 2]);
    end
  end

  monitor_level_decode monitor_one_decode (
    .clk(clk),
    .reset_n(reset_n),
    .level_code(monitor_one_level_q[pgood_cfg_pkg::MONITOR_LEVEL_LSB +: 3]),
    .tol_code(monitor_one_level_q[pgood_cfg_pkg::MONITOR_TOL_LSB +: 2]),
    .level_mv_q(monitor_one_level_mv_q),
    .tol_pct_q(monitor_one_tolerance_pct_q),
    .divider_en_q(monitor_one_divider_en_q)
  );

  monitor_level_decode monitor_two_decode (
    .clk(clk),
    .reset_n(reset_n),
    .level_code(monitor_two_supply_level_q[pgood_cfg_pkg::MONITOR_LEVEL_LSB +: 3]),
    .tol_code(monitor_two_supply_level_q[pgood_cfg_pkg::MONITOR_TOL_LSB +: 2]),
    .level_mv_q(monitor_two_level_mv_q),
    .tol_pct_q(monitor_two_tolerance_pct_q),
    .divider_en_q(monitor_two_divider_en_q)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic write_ctrl_seen;
  assign write_ctrl_seen = wr_ctrl;

  chk_method_overvoltage: assert property (
    write_ctrl_seen && !reg_wdata[6] |-> ##2 ov_check_en_q == 6'h00)
    else $error("overvoltage checks active in undervoltage-only mode");

  chk_method_window: assert property (
    write_ctrl_seen && reg_wdata[6] |-> ##2 ov_check_en_q == $past(reg_wdata[5:0], 2))
    else $error("window mode does not follow source enables");

  chk_supply_enable: assert property (
    uv_check_en_q[5] |-> $past(source_control_q[5]))
    else $error("analog supply supervised while disabled");

  chk_monitor_two_en: assert property (
    write_ctrl_seen |-> ##2 uv_check_en_q[4] == $past(reg_wdata[4], 2))
    else $error("monitor two enable not applied");

  chk_monitor_one_en: assert property (
    write_ctrl_seen |-> ##2 uv_check_en_q[3] == $past(reg_wdata[3], 2))
    else $error("monitor one enable not applied");

  chk_step_up_en: assert property (
    $rose(source_control_q[2]) |=> uv_check_en_q[2])
    else $error("step-up enable not applied");

  chk_step_down_b: assert property (
    $fell(source_control_q[1]) |=> !uv_check_en_q[1] && !ov_check_en_q[1])
    else $error("step-down B still supervised");

  chk_step_down_a: assert property (
    write_ctrl_seen |-> ##2 uv_check_en_q[0] == $past(reg_wdata[0], 2))
    else $error("step-down A enable not applied");

  chk_change_event: assert property (
    write_ctrl_seen && device_operating && reg_wdata[6:0] != source_control_q[6:0]
    |=> config_change_pulse_q ##1 !config_change_pulse_q || $past(write_ctrl_seen))
    else $error("setting change did not flag event");

  chk_mon_one_tol: assert property (
    wr_lvl1 && reg_wdata[4:3] == 2'h3 |-> ##2 monitor_one_tolerance_pct_q == 4'h6)
    else $error("monitor one tolerance decode wrong");

  chk_mon_one_top: assert property (
    wr_lvl1 && reg_wdata[2:1] == 2'h3 |-> ##2 monitor_one_level_mv_q == 11'h708)
    else $error("monitor one top codes not equal");

  chk_divider_sel: assert property (
    ##1 monitor_two_divider_en_q == ($past(monitor_two_supply_level_q[2:0]) != 3'h0))
    else $error("divider enable does not track code zero");

  chk_supply_tol: assert property (
    wr_lvl2 && reg_wdata[7] |-> ##2 analog_supply_tolerance_pct_q == 4'ha)
    else $error("supply wide tolerance decode wrong");

  chk_supply_level: assert property (
    wr_lvl2 |-> ##2 analog_supply_level_mv_q
      == ($past(reg_wdata[5], 2) ? 13'h1388 : 13'h0ce4))
    else $error("supply level decode wrong");

  chk_mon_two_tol: assert property (
    wr_lvl2 && reg_wdata[4:3] == 2'h0 |-> ##2 monitor_two_tolerance_pct_q == 4'h2)
    else $error("monitor two tolerance decode wrong");

  chk_mon_two_low: assert property (
    wr_lvl2 && reg_wdata[2:0] == 3'h0 |-> ##2 monitor_two_level_mv_q == 11'h28a)
    else $error("monitor two lowest level wrong");

  chk_default_load: assert property (
    load_pending_q |=> monitor_two_supply_level_q == $past(default_monitor_two_supply_level)
      && !load_pending_q)
    else $error("defaults not loaded after reset");

  chk_reserved_store: assert property (
    wr_ctrl |=> source_control_q[7] == $past(reg_wdata[7]))
    else $error("reserved bit not stored");

  chk_read_stored: assert property (
    reg_rd && reg_addr == pgood_cfg_pkg::ADDR_SOURCE_CONTROL
    |=> reg_rvalid_q && reg_rdata_q == $past(source_control_q))
    else $error("stored control byte not read back");

  chk_default_masked: assert property (
    load_pending_q |=> source_control_q == ($past(default_source_control) & 8'h7f)
      && monitor_one_level_q == ($past(default_monitor_one_level) & 8'h1f))
    else $error("default bytes not loaded with reserved bits cleared");

  chk_method_copy: assert property (
    write_ctrl_seen |-> ##2 monitor_method_select_q == $past(reg_wdata[6], 2))
    else $error("method select not applied");

  chk_supply_en_write: assert property (
    write_ctrl_seen |-> ##2 uv_check_en_q[5] == $past(reg_wdata[5], 2))
    else $error("analog supply enable not applied");

  chk_down_b_en: assert property (
    write_ctrl_seen |-> ##2 uv_check_en_q[1] == $past(reg_wdata[1], 2))
    else $error("step-down B enable not applied");

  chk_step_up_off: assert property (
    write_ctrl_seen && !reg_wdata[2] |-> ##2 !uv_check_en_q[2] && !ov_check_en_q[2])
    else $error("step-up supervised while disabled");

  chk_divider_one: assert property (
    wr_lvl1 |-> ##2 monitor_one_divider_en_q == ($past(reg_wdata[2:0], 2) != 3'h0))
    else $error("monitor one divider does not track code zero");

  chk_pulse_cause: assert property (
    config_change_pulse_q |-> $past(write_ctrl_seen) && $past(device_operating))
    else $error("setting change event without a live write");

  cov_window_mode: cover property (wr_ctrl && reg_wdata[6] && reg_wdata[5:0] != 6'h00);
  cov_live_change: cover property (config_change_pulse_q);
  cov_read_back: cover property (reg_rd && reg_addr == pgood_cfg_pkg::ADDR_MONITOR_ONE_LEVEL
    ##1 reg_rvalid_q);
  cov_supply_high: cover property (analog_supply_level_mv_q == 13'h1388);

endmodule : power_good_monitor_config
`default_nettype wire

// ---- dv/pgood_host_model.sv ----
// Host side of the register port: single reads and writes, one strobe each.
// Assumes the bench calls its tasks; requests change only on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pgood_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Event seen by the host after a write
  input wire logic config_change_pulse_q
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic set_req(input logic [7:0] a, input logic [7:0] d, input logic w,
                         input logic r);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = r;
  endtask : set_req

  // Idle lines flip so a stale address or data never looks valid
  task automatic clr_req();
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : clr_req

  // Strobe for one edge, collect the answer one cycle later
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
                      output logic [7:0] q, output logic v, output logic p);
    @(negedge clk);
    set_req(a, d, w, r);
    @(negedge clk);
    q = reg_rdata_q;
    v = reg_rvalid_q;
    p = config_change_pulse_q;
    clr_req();
  endtask : xfer
endmodule : pgood_host_model
`default_nettype wire

// ---- dv/power_good_monitor_config_test.sv ----
// Self-checking bench for the power-good configuration bank.
// Assumes the host model drives the register port; expectations come from a register mirror.
`timescale 1ns/1ps
`default_nettype none
module power_good_monitor_config_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic device_operating = 1'b1;
  logic [7:0] dflt [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, q, old, a;
  logic reg_wr, reg_rd, reg_rvalid_q, monitor_method_select_q, v, p;
  logic [5:0] uv_check_en_q, ov_check_en_q;
  logic [10:0] monitor_one_level_mv_q, monitor_two_level_mv_q;
  logic [3:0] monitor_one_tolerance_pct_q, monitor_two_tolerance_pct_q;
  logic [3:0] analog_supply_tolerance_pct_q;
  logic [12:0] analog_supply_level_mv_q;
  logic monitor_one_divider_en_q, monitor_two_divider_en_q, config_change_pulse_q;
  logic [7:0] rm [3];
  logic [31:0] seed = 32'h5ba6837d;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  power_good_monitor_config dut_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .default_source_control(dflt[0]), .default_monitor_one_level(dflt[1]),
    .default_monitor_two_supply_level(dflt[2]), .device_operating(device_operating),
    .uv_check_en_q(uv_check_en_q), .ov_check_en_q(ov_check_en_q),
    .monitor_method_select_q(monitor_method_select_q),
    .monitor_one_level_mv_q(monitor_one_level_mv_q),
    .monitor_one_tolerance_pct_q(monitor_one_tolerance_pct_q),
    .monitor_one_divider_en_q(monitor_one_divider_en_q),
    .monitor_two_level_mv_q(monitor_two_level_mv_q),
    .monitor_two_tolerance_pct_q(monitor_two_tolerance_pct_q),
    .monitor_two_divider_en_q(monitor_two_divider_en_q),
    .analog_supply_level_mv_q(analog_supply_level_mv_q),
    .analog_supply_tolerance_pct_q(analog_supply_tolerance_pct_q),
    .config_change_pulse_q(config_change_pulse_q)
  );

  pgood_host_model host_u (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .config_change_pulse_q(config_change_pulse_q)
  );

  // ----
  // Expectation functions and checks
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [10:0] lvl(input logic [2:0] c);
    case (c)
      3'h0: return 11'h28a;
      3'h1: return 11'h320;
      3'h2: return 11'h3e8;
      3'h3: return 11'h44c;
      3'h4: return 11'h4b0;
      3'h5: return 11'h514;
      default: return 11'h708;
    endcase
  endfunction : lvl

  function automatic logic [3:0] mtol(input logic [1:0] c);
    return (c == 2'h3) ? 4'h6 : {2'h0, c} + 4'h2;
  endfunction : mtol

  function automatic logic [3:0] stol(input logic [1:0] c);
    return c[1] ? 4'ha : {2'h0, c} + 4'h4;
  endfunction : stol

  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    return (x >= 8'h13 && x <= 8'h15) ? rm[2'(x - 8'h13)] : 8'h00;
  endfunction : exp_rd

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic check_all();
    chk(32'(uv_check_en_q), 32'(rm[0][5:0]));
    chk(32'(ov_check_en_q), 32'(rm[0][6] ? rm[0][5:0] : 6'h00));
    chk(32'(monitor_method_select_q), 32'(rm[0][6]));
    chk(32'(monitor_one_level_mv_q), 32'(lvl(rm[1][2:0])));
    chk(32'(monitor_one_tolerance_pct_q), 32'(mtol(rm[1][4:3])));
    chk(32'(monitor_one_divider_en_q), 32'(rm[1][2:0] != 3'h0));
    chk(32'(monitor_two_level_mv_q), 32'(lvl(rm[2][2:0])));
    chk(32'(monitor_two_tolerance_pct_q), 32'(mtol(rm[2][4:3])));
    chk(32'(monitor_two_divider_en_q), 32'(rm[2][2:0] != 3'h0));
    chk(32'(analog_supply_level_mv_q), 32'(rm[2][5] ? 13'h1388 : 13'h0ce4));
    chk(32'(analog_supply_tolerance_pct_q), 32'(stol(rm[2][7:6])));
  endtask : check_all

  task automatic rd_chk(input logic [7:0] x, input logic [7:0] exp);
    host_u.xfer(x, 8'h00, 1'b0, 1'b1, q, v, p);
    chk(32'(v), 32'h1);
    chk(32'(q), 32'(exp));
  endtask : rd_chk

  // Pulse only for a change of bits 6:0 of source control while operating
  task automatic wr_chk(input logic [7:0] x, input logic [7:0] d);
    logic exp_p;
    exp_p = (x == 8'h13) && device_operating && (d[6:0] != rm[0][6:0]);
    host_u.xfer(x, d, 1'b1, 1'b0, q, v, p);
    chk(32'(p), 32'(exp_p));
    if (x >= 8'h13 && x <= 8'h15)
      rm[2'(x - 8'h13)] = d;
    @(negedge clk);
    chk(32'(config_change_pulse_q), 32'h0);
    check_all();
  endtask : wr_chk

  // A write on the load edge must lose against the default store
  task automatic do_reset(input logic load_wr);
    @(negedge clk);
    reset_n = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      dflt[i] = seed[7:0];
    end
    rm = '{8'h00, 8'h00, 8'h00};
    repeat (5) @(negedge clk);
    check_all();
    reset_n = 1'b1;
    if (load_wr)
      host_u.set_req(8'h13, ~dflt[0], 1'b1, 1'b0);
    rm = '{dflt[0] & 8'h7f, dflt[1] & 8'h1f, dflt[2]};
    @(negedge clk);
    chk(32'(config_change_pulse_q), 32'h0);
    if (load_wr)
      host_u.clr_req();
    @(negedge clk);
    check_all();
    for (int i = 0; i < 3; i++)
      rd_chk(8'h13 + 8'(i), rm[i]);
  endtask : do_reset

  // ----
  // Main sequence
  // ----
  initial
  begin
    do_reset(1'b0);
    for (int r = 0; r < 3; r++)
      for (int d = 0; d < 256; d++)
      begin
        seed = lfsr(seed);
        device_operating = seed[0];
        wr_chk(8'h13 + 8'(r), 8'(d));
        rd_chk(8'h13 + 8'(r), 8'(d));
      end
    device_operating = 1'b1;
    wr_chk(8'h13, rm[0] ^ 8'h80);
    wr_chk(8'h13, rm[0]);
    for (int k = 0; k < 300; k++)
    begin
      seed = lfsr(seed);
      a = (seed[9:8] == 2'h3) ? seed[23:16] : 8'h13 + 8'(seed[9:8]);
      device_operating = seed[10];
      if (seed[11])
        wr_chk(a, seed[7:0]);
      else
        rd_chk(a, exp_rd(a));
    end
    old = rm[1];
    host_u.xfer(8'h14, ~old, 1'b1, 1'b1, q, v, p);
    chk(32'(q), 32'(old));
    rm[1] = ~old;
    @(negedge clk);
    check_all();
    do_reset(1'b1);
    close_out();
  end

  // Full run takes about 4600 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
endmodule : power_good_monitor_config_test
`default_nettype wire
